// [common/hub_cfg_pkg.sv]
// Constants for the hub port configuration register slice
package hub_cfg_pkg;

   // ********************************************
   // Register offsets
   // ********************************************
   localparam logic [7:0] dev_config_offset    = 8'h05;
   localparam logic [7:0] charge_enable_offset = 8'h06;
   localparam logic [7:0] removable_offset     = 8'h07;
   localparam logic [7:0] port_active_offset   = 8'h08;

   // ********************************************
   // Field positions
   // ********************************************
   localparam int gang_bit          = 3;
   localparam int report_bit        = 2;
   localparam int reserved_rw_bit   = 1;
   localparam int reserved_one_bit  = 4;
   localparam int override_bit      = 7;
   localparam int port_count        = 4;

   // ********************************************
   // Values after reset
   // ********************************************
   localparam logic       reserved_rw_reset = 1'b0;
   localparam logic [3:0] port_active_reset = 4'hf;
   localparam logic [3:0] removable_reset   = 4'h0;
   localparam logic       override_reset    = 1'b0;

   // ********************************************
   // Strap timing
   // ********************************************
   localparam int sync_stages = 2;

   typedef enum logic [1:0] {
      strap_sync0 = 2'b00,
      strap_sync1 = 2'b01,
      strap_load  = 2'b11,
      strap_done  = 2'b10
   } strap_state_e;

endpackage

// [common/strap_if.sv]
// Captured strap levels passed from the strap capture to the registers
`timescale 1ns/100ps
interface strap_if;
   logic       gang;
   logic       report;
   logic [3:0] charge;
   logic       load;
   logic       done;

   modport capture (
      output gang,
      output report,
      output charge,
      output load,
      output done
   );
   modport regs (
      input gang,
      input report,
      input charge,
      input load,
      input done
   );
endinterface

// [hdl/hub_port_config_registers.sv]
// Port configuration registers of a four-port hub
//
// Behaviour
// - On reset release, gang strap level is captured into config bit 3.
// - Report enabled, not ganged: each port has its own power output.
// - Report enabled, ganged: all ports powered through the first output.
// - In I2C mode, EEPROM loads may set gang and report-disable bits.
// - In SMBus mode, the host may overwrite gang and report-disable bits.
// - On reset release, report strap level is captured into config bit 2.
// - Power switching status is reported only while report-disable is 0.
// - Reserved config bit 0 always reads zero.
// - Unused upper charge and removable bits are read-only zero.
// - Each charge-enable bit turns its port's charging features on or off.
// - Charge-enable bit n controls downstream port n+1.
// - Charge-enable defaults load from the shared power pins at release.
// - EEPROM or SMBus writes may replace the charge-enable bits.
// - Override clear: removable bits read-only, taken from OTP memory.
// - Override set: removable bits writable by EEPROM or SMBus.
// - A write setting override also updates its removable bits.
// - Removable bit 1 means removable, 0 permanent; bit 0 is port 1.
// - Override clear: removable bits read as inverted OTP non-removable.
// - Each port-used bit enables its port; bit 0 is port 1.
`timescale 1ns/100ps
module hub_port_config_registers
   import hub_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Configuration access from EEPROM loader or SMBus slave
   input  wire logic       cfg_mode_en,
   input  wire logic       cfg_wr,
   input  wire logic [7:0] cfg_addr,
   input  wire logic [7:0] cfg_wdata,
   output logic      [7:0] cfg_rdata,
   output logic            cfg_ready,
   // Strap pins
   input  wire logic       gang_strap_pin,
   input  wire logic       power_report_strap_pin,
   // Shared power control and charge enable pins
   input  wire logic [3:0] port_power_control_in,
   output logic      [3:0] port_power_control_out,
   output logic      [3:0] port_power_control_oe,
   // Hub core
   input  wire logic [3:0] port_power_request,
   input  wire logic [3:0] otp_non_removable,
   output logic            ganged,
   output logic            power_report_disable_n,
   output logic            status_report_en,
   output logic      [3:0] charge_port_enable_bits,
   output logic      [3:0] port_removable,
   output logic      [3:0] port_enable
);

   strap_if straps ();

   logic       reserved_rw;
   logic       removable_override;
   logic [3:0] removable_store;
   logic [3:0] removable_view;
   logic [3:0] own_power;
   logic       gang_power;
   logic [3:0] next_power_out;
   logic [3:0] next_power_oe;
   logic [7:0] dev_word;
   logic [7:0] charge_word;
   logic [7:0] removable_word;
   logic [7:0] used_word;
   logic [7:0] next_rdata;
   logic       write_ok;
   logic       wr_dev_config;
   logic       wr_charge;
   logic       wr_removable;
   logic       wr_port_active;

   // ********************************************
   // Strap capture
   // ********************************************
   strap_capture i_strap_capture (
      .clk                    (clk),
      .reset                  (reset),
      .gang_strap_pin         (gang_strap_pin),
      .power_report_strap_pin (power_report_strap_pin),
      .charge_enable_strap    (port_power_control_in),
      .straps                 (straps)
   );

   function automatic logic hits(input logic [7:0] addr,
                                 input logic [7:0] offset);
      hits = (addr == offset);
   endfunction

   // ********************************************
   // Write strobes, one per register
   // ********************************************
   // Writes only in I2C or SMBus mode, after straps are in
   assign write_ok       = cfg_wr && cfg_mode_en && straps.done;
   assign wr_dev_config  = write_ok && hits(cfg_addr, dev_config_offset);
   assign wr_charge      = write_ok && hits(cfg_addr, charge_enable_offset);
   assign wr_removable   = write_ok && hits(cfg_addr, removable_offset);
   assign wr_port_active = write_ok && hits(cfg_addr, port_active_offset);

   // ********************************************
   // Device configuration low bits
   // ********************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ganged <= 1'b0;
      end else if (straps.load) begin
         ganged <= straps.gang;
      end else if (wr_dev_config) begin
         ganged <= cfg_wdata[gang_bit];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         power_report_disable_n <= 1'b0;
      end else if (straps.load) begin
         power_report_disable_n <= straps.report;
      end else if (wr_dev_config) begin
         power_report_disable_n <= cfg_wdata[report_bit];
      end
   end

   // Reserved writable bit kept as written
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reserved_rw <= reserved_rw_reset;
      end else if (wr_dev_config) begin
         reserved_rw <= cfg_wdata[reserved_rw_bit];
      end
   end

   // ********************************************
   // Charge enable
   // ********************************************
   // Strap levels first, host writes afterwards
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         charge_port_enable_bits <= 4'h0;
      end else if (straps.load) begin
         charge_port_enable_bits <= straps.charge;
      end else if (wr_charge) begin
         charge_port_enable_bits <= cfg_wdata[3:0];
      end
   end

   // ********************************************
   // Removable configuration
   // ********************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         removable_override <= override_reset;
      end else if (wr_removable) begin
         removable_override <= cfg_wdata[override_bit];
      end
   end

   // Stored bits follow a write only when it also sets the override
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         removable_store <= removable_reset;
      end else if (wr_removable && cfg_wdata[override_bit]) begin
         removable_store <= cfg_wdata[3:0];
      end
   end

   // Override clear shows the inverted OTP field, bit p is port p+1
   for (genvar p = 0; p < port_count; p++) begin : g_removable
      assign removable_view[p] = removable_override
                                 ? removable_store[p]
                                 : !otp_non_removable[p];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         port_removable <= removable_reset;
      end else begin
         port_removable <= removable_view;
      end
   end

   // ********************************************
   // Port used configuration
   // ********************************************
   // Any pattern is stored as written
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         port_enable <= port_active_reset;
      end else if (wr_port_active) begin
         port_enable <= cfg_wdata[3:0];
      end
   end

   // ********************************************
   // Power switch outputs and status reporting
   // ********************************************
   // Requests count only on used ports
   assign own_power  = port_power_request & port_enable;
   assign gang_power = |own_power;

   for (genvar p = 0; p < port_count; p++) begin : g_port_power
      logic drive;
      logic enable;
      always_comb begin
         drive  = 1'b0;
         enable = 1'b0;
         if (straps.done) begin
            if (power_report_disable_n) begin
               // No switching reported: used ports stay powered
               drive  = port_enable[p];
               enable = 1'b1;
            end else if (ganged) begin
               // Shared switch on the first output only
               drive  = (p == 0) ? gang_power : 1'b0;
               enable = (p == 0);
            end else begin
               drive  = own_power[p];
               enable = 1'b1;
            end
         end
      end
      assign next_power_out[p] = drive;
      assign next_power_oe[p]  = enable;
   end

   // Pins stay inputs until the straps are in
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         port_power_control_out <= 4'h0;
         port_power_control_oe  <= 4'h0;
      end else begin
         port_power_control_out <= next_power_out;
         port_power_control_oe  <= next_power_oe;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_report_en <= 1'b0;
      end else begin
         status_report_en <= straps.done && !power_report_disable_n;
      end
   end

   // Ready one edge after the straps settle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_ready <= 1'b0;
      end else begin
         cfg_ready <= straps.done;
      end
   end

   // ********************************************
   // Read back
   // ********************************************
   // Bit 4 of the device configuration reads one
   always_comb begin
      dev_word                   = 8'h00;
      dev_word[reserved_one_bit] = 1'b1;
      dev_word[gang_bit]         = ganged;
      dev_word[report_bit]       = power_report_disable_n;
      dev_word[reserved_rw_bit]  = reserved_rw;
      dev_word[0]                = 1'b0;
   end

   always_comb begin
      removable_word               = 8'h00;
      removable_word[override_bit] = removable_override;
      removable_word[3:0]          = removable_view;
   end

   assign charge_word = {4'h0, charge_port_enable_bits};
   assign used_word   = {4'h0, port_enable};

   always_comb begin
      next_rdata = 8'h00;
      if (hits(cfg_addr, dev_config_offset)) begin
         next_rdata = dev_word;
      end else if (hits(cfg_addr, charge_enable_offset)) begin
         next_rdata = charge_word;
      end else if (hits(cfg_addr, removable_offset)) begin
         next_rdata = removable_word;
      end else if (hits(cfg_addr, port_active_offset)) begin
         next_rdata = used_word;
      end
   end

   // Data of the address seen one edge earlier
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_rdata <= 8'h00;
      end else begin
         cfg_rdata <= next_rdata;
      end
   end

endmodule

// [hdl/strap_capture.sv]
// Strap pin synchronisers and capture after reset release
`timescale 1ns/100ps
module strap_capture
   import hub_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Strap pins
   input  wire logic       gang_strap_pin,
   input  wire logic       power_report_strap_pin,
   input  wire logic [3:0] charge_enable_strap,
   // Captured levels
   strap_if.capture        straps
);

   logic [5:0]   sync_a;
   logic [5:0]   sync_b;
   strap_state_e state;

   // ********************************************
   // Two-flop synchronisers
   // ********************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_a <= 6'h00;
         sync_b <= 6'h00;
      end else begin
         sync_a <= {gang_strap_pin, power_report_strap_pin,
                    charge_enable_strap};
         sync_b <= sync_a;
      end
   end

   // ********************************************
   // Wait for synchronised levels, then load once
   // ********************************************
   // Load only once the second stage holds the pin levels
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= strap_sync0;
      end else begin
         unique case (state)
            strap_sync0: state <= strap_sync1;
            strap_sync1: state <= strap_load;
            strap_load:  state <= strap_done;
            strap_done:  state <= strap_done;
         endcase
      end
   end

   assign straps.gang   = sync_b[5];
   assign straps.report = sync_b[4];
   assign straps.charge = sync_b[3:0];
   assign straps.load   = (state == strap_load);
   assign straps.done   = (state == strap_done);

endmodule

// [test/cfg_host_model.sv]
// Configuration host model issuing register writes and read addresses
`timescale 1ns/100ps
module cfg_host_model
   import hub_cfg_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Register access
   output logic            cfg_mode_en,
   output logic            cfg_wr,
   output logic      [7:0] cfg_addr,
   output logic      [7:0] cfg_wdata
);
   initial begin
      cfg_mode_en = 1'b1;
      cfg_wr = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
   end
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == dev_config_offset) v[reserved_rw_bit] = reserved_rw_reset;
      if (a == port_active_offset && !(v[0] | v[2])) v[0] = 1'b1;
      @(posedge clk);
      cfg_addr <= a;
      cfg_wdata <= v;
      cfg_wr <= 1'b1;
      @(posedge clk);
      cfg_wr <= 1'b0;
      cfg_wdata <= ~v;
   endtask
   task automatic mode(input logic m);
      @(posedge clk);
      cfg_mode_en <= m;
   endtask
   task automatic look(input logic [7:0] a);
      @(posedge clk);
      cfg_addr <= a;
   endtask
endmodule

// [test/hub_cfg_monitor.sv]
// Checker on the ports of the hub port configuration registers
`timescale 1ns/100ps
module hub_cfg_monitor
   import hub_cfg_pkg::*;
(
   // Clock, reset, access
   input logic       clk,
   input logic       reset,
   input logic       cfg_mode_en,
   input logic       cfg_wr,
   input logic [7:0] cfg_addr,
   input logic [7:0] cfg_wdata,
   input logic [7:0] cfg_rdata,
   input logic       cfg_ready,
   // Pins and core
   input logic       gang_strap_pin,
   input logic       power_report_strap_pin,
   input logic [3:0] port_power_control_in,
   input logic [3:0] port_power_control_out,
   input logic [3:0] port_power_control_oe,
   input logic [3:0] port_power_request,
   input logic [3:0] otp_non_removable,
   input logic       ganged,
   input logic       power_report_disable_n,
   input logic       status_report_en,
   input logic [3:0] charge_port_enable_bits,
   input logic [3:0] port_enable
);
   logic       wr_ok;
   logic [3:0] wd_low;
   logic       run;
   assign wr_ok = cfg_ready && cfg_mode_en && cfg_wr;
   assign wd_low = cfg_wdata[3:0];
   assign run = cfg_ready && !power_report_disable_n;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   chk_strap_load: assert property (
      $rose(cfg_ready) |-> ganged == gang_strap_pin
      && power_report_disable_n == power_report_strap_pin
      && charge_port_enable_bits == port_power_control_in)
      else $error("strap levels not captured");
   chk_status_report: assert property (
      cfg_ready && $past(cfg_ready) && $stable(power_report_disable_n)
      |-> status_report_en == !power_report_disable_n)
      else $error("status report enable wrong");
   chk_ganged_power: assert property (
      run && ganged |=> port_power_control_oe == 4'h1 &&
      port_power_control_out ==
      {3'h0, |($past(port_power_request) & $past(port_enable))})
      else $error("ganged power output wrong");
   chk_port_power: assert property (
      run && !ganged |=> port_power_control_oe == 4'hf &&
      port_power_control_out ==
      ($past(port_power_request) & $past(port_enable)))
      else $error("per port power output wrong");
   chk_config_read: assert property (
      $past(cfg_addr) == dev_config_offset
      |-> cfg_rdata[0] == 1'b0 && cfg_rdata[7:4] == 4'h1)
      else $error("config fixed bits wrong");
   chk_charge_read: assert property (
      $past(cfg_addr) == charge_enable_offset |-> cfg_rdata[7:4] == 4'h0)
      else $error("charge upper bits not zero");
   chk_removable_view: assert property (
      $past(cfg_addr) == removable_offset && !cfg_rdata[7]
      |-> cfg_rdata[6:0] == {3'h0, ~$past(otp_non_removable)})
      else $error("removable view wrong");
   chk_used_write: assert property (
      wr_ok && cfg_addr == port_active_offset |=> port_enable == $past(wd_low))
      else $error("port used write lost");
   chk_charge_write: assert property (
      wr_ok && cfg_addr == charge_enable_offset
      |=> charge_port_enable_bits == $past(wd_low))
      else $error("charge enable write lost");
endmodule
bind hub_port_config_registers hub_cfg_monitor i_hub_cfg_monitor (.*);

// [test/hub_port_config_registers_test.sv]
// Self-checking bench for the hub port configuration registers
`timescale 1ns/100ps
module hub_port_config_registers_test;
   import hub_cfg_pkg::*;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       cfg_mode_en, cfg_wr, cfg_ready;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
   logic       gang_strap_pin = 1'b1;
   logic       power_report_strap_pin = 1'b0;
   logic [3:0] port_power_control_in = 4'ha;
   logic [3:0] port_power_request = 4'h0;
   logic [3:0] otp_non_removable = 4'h3;
   logic [3:0] port_power_control_out, port_power_control_oe;
   logic       ganged, power_report_disable_n, status_report_en;
   logic [3:0] charge_port_enable_bits, port_removable, port_enable;
   int         fail_count = 0;
   int         total_checks = 0;

   always #25 clk = ~clk;
   hub_port_config_registers i_hub_port_config_registers (.*);
   cfg_host_model i_cfg_host_model (.*);

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_cfg_host_model.look(a);
      tick(2);
      check(cfg_rdata, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_cfg_host_model.put(a, d);
      tick(2);
   endtask
   task automatic set_req(input logic [3:0] r);
      @(posedge clk);
      port_power_request <= r;
      tick(2);
   endtask
   task automatic t_straps;
      check(ganged, 1'b1);
      check(power_report_disable_n, 1'b0);
      check(charge_port_enable_bits, 4'ha);
      rd(dev_config_offset, 8'h18);
      rd(removable_offset, 8'h0c);
      rd(port_active_offset, 8'h0f);
      rd(8'h20, 8'h00);
   endtask
   task automatic t_power;
      set_req(4'h4);
      check(port_power_control_out, 4'h1);
      check(port_power_control_oe, 4'h1);
      wr(dev_config_offset, 8'h00);
      set_req(4'h5);
      check(port_power_control_out, 4'h5);
      check(port_power_control_oe, 4'hf);
      check(status_report_en, 1'b1);
      wr(port_active_offset, 8'hf3);
      check(port_power_control_out, 4'h1);
      rd(port_active_offset, 8'h03);
      wr(dev_config_offset, 8'h0c);
      check(status_report_en, 1'b0);
      rd(dev_config_offset, 8'h1c);
      wr(dev_config_offset, 8'h09);
      rd(dev_config_offset, 8'h18);
   endtask
   task automatic t_charge;
      wr(charge_enable_offset, 8'hf1);
      check(charge_port_enable_bits, 4'h1);
      rd(charge_enable_offset, 8'h01);
      wr(charge_enable_offset, 8'h0e);
      check(charge_port_enable_bits, 4'he);
   endtask
   task automatic t_removable;
      wr(removable_offset, 8'hf5);
      check(port_removable, 4'h5);
      rd(removable_offset, 8'h85);
      wr(removable_offset, 8'h0a);
      tick(1);
      check(port_removable, 4'hc);
      rd(removable_offset, 8'h0c);
   endtask
   task automatic t_mode_off;
      i_cfg_host_model.mode(1'b0);
      wr(port_active_offset, 8'h05);
      check(port_enable, 4'h3);
      i_cfg_host_model.mode(1'b1);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 20 && !cfg_ready; i++) tick(1);
      if (cfg_ready !== 1'b1) fail_count++;
      else begin
         t_straps();
         t_power();
         t_charge();
         t_removable();
         t_mode_off();
      end
      final_report();
   end
endmodule
